// ==== src/iszx_exec.sv ====
// Execution unit for the increment-and-skip-if-zero instruction.
// Assumes the fetch pipeline presents one word per instruction cycle and the
// file-register datapath returns the addressed byte combinationally and writes
// back to the address it was shown in the decode cycle.
`timescale 1ns/1ps
module iszx_exec
    import iszx_pkg::*;
(
    input wire logic i_mclk,
    input wire logic i_rstn,
    input wire logic i_insn_vld,
    input wire logic [iszx_pkg::INSN_W-1:0] i_insn,
    input wire logic [iszx_pkg::DATA_W-1:0] i_file_rdata,
    output logic [iszx_pkg::ADDR_W-1:0] o_file_addr,
    output logic o_file_we,
    output logic [iszx_pkg::DATA_W-1:0] o_file_wdata,
    output logic o_w_we,
    output logic [iszx_pkg::DATA_W-1:0] o_w_wdata,
    output logic o_status_we,
    output logic o_flush,
    output logic o_exec_nop
);
    import iszx_pkg::*;

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    logic hit;
    logic dest_f;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] sum;
    logic zero;
    iszx_state_t state_q;
    iszx_state_t state_d;

    always_comb
    begin
        // A flushed slot executes nothing, even if it decodes as a hit
        hit = i_insn_vld && (state_q == ISZX_RUN)
            && (i_insn[OPC_LSB +: OPC_W] == OPC_INC_SKZ);
        dest_f = i_insn[DEST_BIT];
        addr = i_insn[ADDR_LSB +: ADDR_W];
        sum = i_file_rdata + DATA_ONE;
        zero = (sum == DATA_ZERO);
    end

    // ------------------------------------------------------------
    // Registered results and skip sequencing
    // ------------------------------------------------------------
    logic [ADDR_W-1:0] file_addr_q, file_addr_d;
    logic file_we_q, file_we_d;
    logic [DATA_W-1:0] file_wdata_q, file_wdata_d;
    logic w_we_q, w_we_d;
    logic [DATA_W-1:0] w_wdata_q, w_wdata_d;

    always_comb
    begin
        state_d = ISZX_RUN;
        file_addr_d = addr;
        file_we_d = 1'b0;
        file_wdata_d = file_wdata_q;
        w_we_d = 1'b0;
        w_wdata_d = w_wdata_q;
        case (state_q)
            ISZX_RUN:
            begin
                if (hit)
                begin
                    if (dest_f)
                    begin
                        file_we_d = 1'b1;
                        file_wdata_d = sum;
                    end
                    else
                    begin
                        w_we_d = 1'b1;
                        w_wdata_d = sum;
                    end
                    if (zero)
                    begin
                        state_d = ISZX_FLUSH;
                    end
                end
            end
            ISZX_FLUSH:
            begin
                state_d = ISZX_RUN;
            end
            default:
            begin
                state_d = ISZX_RUN;
            end
        endcase
    end

    always_ff @(posedge i_mclk)
    begin
        if (!i_rstn)
        begin
            state_q <= ISZX_RUN;
            file_addr_q <= ADDR_RST;
            file_we_q <= 1'b0;
            file_wdata_q <= DATA_RST;
            w_we_q <= 1'b0;
            w_wdata_q <= DATA_RST;
        end
        else
        begin
            state_q <= state_d;
            file_addr_q <= file_addr_d;
            file_we_q <= file_we_d;
            file_wdata_q <= file_wdata_d;
            w_we_q <= w_we_d;
            w_wdata_q <= w_wdata_d;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    // Read address is combinational so the operand is seen in the decode cycle
    assign o_file_addr = (state_q == ISZX_RUN && i_insn_vld) ? addr : file_addr_q;
    assign o_file_we = file_we_q;
    assign o_file_wdata = file_wdata_q;
    assign o_w_we = w_we_q;
    assign o_w_wdata = w_wdata_q;
    assign o_status_we = 1'b0;
    assign o_flush = hit && zero;
    assign o_exec_nop = (state_q == ISZX_FLUSH);

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge i_mclk);
    endclocking
    default disable iff (!i_rstn);

    a_inc_to_w: assert property (hit && !dest_f |=> w_we_q && !file_we_q
        && w_wdata_q == $past(i_file_rdata) + DATA_ONE)
        else $error("Working register result wrong");

    a_file_keep: assert property (hit && !dest_f |=> !o_file_we)
        else $error("File register written for working destination");

    a_inc_to_file: assert property (hit && dest_f |=> file_we_q && !w_we_q
        && file_wdata_q == $past(i_file_rdata) + DATA_ONE
        && file_addr_q == $past(i_insn[4:0]))
        else $error("File write-back wrong");

    a_decode_hit: assert property (i_insn_vld && !o_exec_nop
        && i_insn[11:6] == 6'h0f |=> o_file_we || o_w_we)
        else $error("Opcode not decoded");

    a_other_quiet: assert property (i_insn_vld && i_insn[11:6] != 6'h0f
        |-> !o_flush ##1 !o_file_we && !o_w_we)
        else $error("Other opcode had effect");

    a_idle_quiet: assert property (!i_insn_vld
        |-> !o_flush ##1 !o_file_we && !o_w_we)
        else $error("Idle cycle had effect");

    a_one_dest: assert property (!(o_file_we && o_w_we))
        else $error("Result written to both destinations");

    a_w_hold: assert property (!o_w_we
        |-> o_w_wdata == $past(o_w_wdata))
        else $error("Working result changed without a write");

    a_file_hold: assert property (!o_file_we
        |-> o_file_wdata == $past(o_file_wdata))
        else $error("File result changed without a write");

    a_wb_addr: assert property (o_file_we && !i_insn_vld
        |-> o_file_addr == $past(i_insn[4:0]))
        else $error("Write-back address wrong");

    a_skip_nop: assert property (hit && i_file_rdata == 8'hff
        |-> o_flush ##1 o_exec_nop ##1 !o_exec_nop)
        else $error("Skip did not insert one no-op");

    a_flush_cause: assert property (o_flush
        |-> i_insn_vld && !o_exec_nop && i_file_rdata == 8'hff)
        else $error("Flush without a zero result");

    a_flush_slot: assert property (o_exec_nop |-> !o_flush)
        else $error("Flushed slot raised a flush");

    a_no_skip: assert property (hit && i_file_rdata != 8'hff
        |-> !o_flush ##1 !o_exec_nop)
        else $error("Spurious skip");

    a_nop_quiet: assert property (o_exec_nop |=> !file_we_q && !w_we_q)
        else $error("Flushed slot had effect");

    a_nop_once: assert property (o_exec_nop |=> !o_exec_nop)
        else $error("No-op slot lasted too long");

    a_reset_quiet: assert property (disable iff (1'b0) !i_rstn
        |=> !o_file_we && !o_w_we && !o_exec_nop)
        else $error("Outputs active after reset");

    a_wrap_zero: assert property (hit && !dest_f && i_file_rdata == 8'hff
        |=> w_wdata_q == 8'h00)
        else $error("Increment did not wrap");

    a_no_status: assert property (!o_status_we)
        else $error("Status written");

    a_addr_range: assert property (hit |-> o_file_addr == i_insn[4:0])
        else $error("Operand address wrong");

    // ------------------------------------------------------------
    // Coverage
    // ------------------------------------------------------------
    c_skip_w: cover property (hit && zero && !dest_f);
    c_skip_f: cover property (hit && zero && dest_f);
    c_plain_f: cover property (hit && !zero && dest_f);
    c_back_to_back: cover property (hit ##1 hit);
    c_other_opc: cover property (i_insn_vld && i_insn[11:6] != 6'h0f);
endmodule

// ==== src/iszx_pkg.sv ====
// Constants for the increment-and-skip-if-zero execution block.
// Assumes a 12-bit instruction word and an 8-bit data path.
package iszx_pkg;
    localparam int INSN_W = 12;
    localparam int DATA_W = 8;
    localparam int ADDR_W = 5;
    localparam int OPC_W = 6;
    localparam logic [5:0] OPC_INC_SKZ = 6'h0f;
    localparam int OPC_LSB = 6;
    localparam int DEST_BIT = 5;
    localparam int ADDR_LSB = 0;
    localparam logic [7:0] DATA_RST = 8'h00;
    localparam logic [7:0] DATA_ONE = 8'h01;
    localparam logic [7:0] DATA_ZERO = 8'h00;
    localparam logic [4:0] ADDR_RST = 5'h00;
    localparam int CYC_NO_SKIP = 1;
    localparam int CYC_SKIP = 2;
    typedef enum logic [0:0] {ISZX_RUN, ISZX_FLUSH} iszx_state_t;
endpackage

// ==== testbench/iszx_file_model.sv ====
// File-register datapath model facing the execution unit.
// Assumes a write-back goes to the address shown in the decode cycle before it.
`timescale 1ns/1ps
module iszx_file_model
    import iszx_pkg::*;
(
    input wire logic i_mclk,
    input wire logic i_load,
    input wire logic [iszx_pkg::ADDR_W-1:0] i_load_addr,
    input wire logic [iszx_pkg::DATA_W-1:0] i_load_data,
    input wire logic [iszx_pkg::ADDR_W-1:0] i_file_addr,
    input wire logic i_file_we,
    input wire logic [iszx_pkg::DATA_W-1:0] i_file_wdata,
    output logic [iszx_pkg::DATA_W-1:0] o_file_rdata
);
    import iszx_pkg::*;
    logic [DATA_W-1:0] mem [32];
    // Operand address of the decode cycle, target of the write that follows
    logic [ADDR_W-1:0] wr_addr_q;
    assign o_file_rdata = mem[i_file_addr];
    always_ff @(posedge i_mclk)
    begin
        wr_addr_q <= i_file_addr;
        if (i_load)
            mem[i_load_addr] <= i_load_data;
        else if (i_file_we)
            mem[wr_addr_q] <= i_file_wdata;
    end
endmodule

// ==== testbench/tb_top.sv ====
// Self-checking bench for the increment-and-skip-if-zero unit.
// Assumes fixed latencies: flush in decode cycle, writes one cycle later.
`timescale 1ns/1ps
module tb_top;
    import iszx_pkg::*;
    logic i_mclk = 0, i_rstn = 0, i_insn_vld = 0;
    logic [INSN_W-1:0] i_insn = '0;
    logic [DATA_W-1:0] rd, fwd, wwd;
    logic [ADDR_W-1:0] fa;
    logic fwe, wwe, swe, fl, nop;
    logic ld = 0;
    logic [ADDR_W-1:0] ld_a = '0;
    logic [DATA_W-1:0] ld_d = '0;
    int n_fail = 0;
    int total_checks = 0;
    always #50 i_mclk = ~i_mclk;
    iszx_exec iszx_exec_i (.i_mclk(i_mclk), .i_rstn(i_rstn), .i_insn_vld(i_insn_vld),
        .i_insn(i_insn), .i_file_rdata(rd), .o_file_addr(fa), .o_file_we(fwe),
        .o_file_wdata(fwd), .o_w_we(wwe), .o_w_wdata(wwd), .o_status_we(swe),
        .o_flush(fl), .o_exec_nop(nop));
    iszx_file_model iszx_file_model_i (.i_mclk(i_mclk), .i_load(ld), .i_load_addr(ld_a),
        .i_load_data(ld_d), .i_file_addr(fa), .i_file_we(fwe), .i_file_wdata(fwd),
        .o_file_rdata(rd));
    task automatic chk(string nm, logic [7:0] seen, logic [7:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("unexpected %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wrap_up();
        if (n_fail == 0 && total_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // Preload one file register; the strobe stays up until the next request
    task automatic load(logic [4:0] a, logic [7:0] d);
        ld = 1;
        ld_a = a;
        ld_d = d;
        @(negedge i_mclk);
    endtask
    // One instruction at a falling edge; returns at the next falling edge
    task automatic issue(logic [11:0] w, logic f);
        ld = 0;
        i_insn_vld = 1;
        i_insn = w;
        #10 chk("flush", fl, f);
        @(negedge i_mclk);
        i_insn_vld = 0;
    endtask
    task automatic t_to_w();
        load(5'h07, 8'h10);
        issue(12'h3c7, 1'b0);
        chk("w_we", wwe, 8'h01);
        chk("w_wdata", wwd, 8'h11);
        chk("file_we", fwe, 8'h00);
        chk("file_addr", fa, 8'h07);
        chk("nop", nop, 8'h00);
        @(negedge i_mclk) chk("mem7", iszx_file_model_i.mem[7], 8'h10);
    endtask
    task automatic t_wrap_f();
        load(5'h1f, 8'hff);
        issue(12'h3ff, 1'b1);
        chk("file_we", fwe, 8'h01);
        chk("file_wdata", fwd, 8'h00);
        chk("nop", nop, 8'h01);
        chk("status_we", swe, 8'h00);
        @(negedge i_mclk) chk("mem31", iszx_file_model_i.mem[31], 8'h00);
        chk("nop end", nop, 8'h00);
    endtask
    task automatic t_skip_b2b();
        load(5'h02, 8'hff);
        load(5'h03, 8'hff);
        ld = 0;
        i_insn_vld = 1;
        i_insn = 12'h3c2;
        #10 chk("flush", fl, 8'h01);
        @(negedge i_mclk) i_insn = 12'h3e3;
        chk("w_we", wwe, 8'h01);
        chk("w_wdata", wwd, 8'h00);
        chk("nop", nop, 8'h01);
        #10 chk("slot flush", fl, 8'h00);
        @(negedge i_mclk) i_insn_vld = 0;
        chk("slot w_we", wwe, 8'h00);
        chk("file_we", fwe, 8'h00);
        @(negedge i_mclk) chk("mem3", iszx_file_model_i.mem[3], 8'hff);
        chk("mem2", iszx_file_model_i.mem[2], 8'hff);
    endtask
    task automatic t_b2b_f();
        load(5'h04, 8'h20);
        load(5'h05, 8'h30);
        ld = 0;
        i_insn_vld = 1;
        i_insn = 12'h3e4;
        @(negedge i_mclk) i_insn = 12'h3e5;
        chk("file_we b2b", fwe, 8'h01);
        @(negedge i_mclk) i_insn_vld = 0;
        chk("file_wdata b2b", fwd, 8'h31);
        @(negedge i_mclk) chk("mem4", iszx_file_model_i.mem[4], 8'h21);
        chk("mem5", iszx_file_model_i.mem[5], 8'h31);
    endtask
    task automatic t_other();
        issue(12'h3a2, 1'b0);
        chk("other we", {fwe, wwe}, 8'h00);
        @(negedge i_mclk) chk("mem2 kept", iszx_file_model_i.mem[2], 8'hff);
    endtask
    initial
    begin
        repeat (4) @(negedge i_mclk);
        i_rstn = 1;
        chk("reset out", {fwe, wwe, fl, nop}, 8'h00);
        t_to_w();
        t_wrap_f();
        t_skip_b2b();
        t_b2b_f();
        t_other();
        wrap_up();
    end
    initial
    begin
        #100000 n_fail++;
        wrap_up();
    end
endmodule
